/* inc/fpep_defs.vh */
// Constants and field layouts for the flash program/erase protect block.
// Notes on behaviour
// - Array reads return no data while software write enable is one.
// - Overlapping RAM stays readable and writable regardless of write enable.
// - Malfunction during program/erase sets error flag, enters error protection.
// - Protection keeps control and block select registers, aborts operation.
// - Under protection, setting program or erase bits again is ignored.
// - Under protection, verify bits may still be set, entering verify mode.
// - Array read or fetch during program/erase sets error flag.
// - Non-reset exception handling during program/erase sets error flag.
// - Sleep instruction or software standby during program/erase sets flag.
// - Other bus master owning bus during program/erase sets error flag.
// - Only reset or hardware standby clears protection; software cannot.
`ifndef FPEP_DEFS_VH
`define FPEP_DEFS_VH
`define FPEP_CTLA_WREN_BIT 6
`define FPEP_CTLA_EVER_BIT 3
`define FPEP_CTLA_PVER_BIT 2
`define FPEP_CTLA_ERASE_BIT 1
`define FPEP_CTLA_PROG_BIT 0
`define FPEP_CTLB_ERR_BIT 7
`define FPEP_CTLB_EVER_BIT 3
`define FPEP_CTLB_PVER_BIT 2
`define FPEP_CTLB_ERASE_BIT 1
`define FPEP_CTLB_PROG_BIT 0
`define FPEP_CTL_RESET 8'h00
`define FPEP_BLK_RESET 8'h00
`define FPEP_PROG_UNIT_BYTES 128
`endif

/* verification/fpep_cpu_model.sv */
// Behavioural CPU and bus-master side raising access events on request.
`timescale 1ns/1ns
module fpep_cpu_model
(
    input wire clock_i,
    input wire [2:0] op_i,
    output reg [4:0] ev_o
);
    // Code 1 fetches from overlap RAM, and no interrupt fires unasked.
    initial ev_o = 5'h00;
    always @(posedge clock_i)
    begin
        ev_o <= (op_i == 3'h0) ? 5'h00 : 5'h01 << (op_i - 3'h1);
    end
endmodule

/* verification/fpep_props.sv */
// Assertions on read lockout, RAM access and the protection latch, seen from the top ports.
`timescale 1ns/1ns
module fpep_props
(
    input wire clock_i,
    input wire arst_n_i,
    input wire hw_standby_i,
    input wire bus_read_i,
    input wire ram_overlap_i,
    input wire exception_i,
    input wire [7:0] ctl_a_o,
    input wire [7:0] ctl_b_o,
    input wire program_active_o,
    input wire erase_active_o,
    input wire flash_read_en_o,
    input wire ram_access_en_o,
    input wire flash_error_flag_o
);
    wire act = program_active_o | erase_active_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    a_read_lockout: assert property ($past(ctl_a_o[6]) && ctl_a_o[6] |->
        !flash_read_en_o) else $error("array open");
    a_ram_open: assert property (bus_read_i && ram_overlap_i |=>
        ram_access_en_o) else $error("ram closed");
    a_err_abort: assert property (flash_error_flag_o |-> !act)
        else $error("op runs under error");
    a_err_sticky: assert property (flash_error_flag_o && !hw_standby_i
        && !$past(hw_standby_i) |=> flash_error_flag_o)
        else $error("flag lost");
    a_regs_kept: assert property ($rose(flash_error_flag_o) |->
        $stable(ctl_a_o)) else $error("ctl changed");
    a_read_err: assert property (act && bus_read_i && !ram_overlap_i
        |-> ##[1:3] flash_error_flag_o) else $error("read missed");
    a_exc_err: assert property (act && exception_i |-> ##[1:3]
        flash_error_flag_o) else $error("exception missed");
    a_flag_status: assert property (flash_error_flag_o |->
        ctl_b_o[7]) else $error("status bit");
    cover property (act ##1 flash_error_flag_o);
    cover property (erase_active_o);
    cover property ($rose(flash_error_flag_o));
endmodule
bind fpep_top fpep_props u_fpep_props (.*);

/* verification/tb_top.sv */
// Self-checking bench for the flash program/erase protect block.
`timescale 1ns/1ns
module tb_top;
    reg clock_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg stby = 1'b0;
    reg [3:0] we = 4'h0;
    reg [7:0] wd = 8'h00;
    reg [2:0] op = 3'h0;
    wire [7:0] ca, cb, ba, bb;
    wire [4:0] ev;
    wire pa, ea, va, fr, ra, fl;
    integer fails = 0;
    integer checked = 0;
    integer o;
    integer fr_cnt = 0;
    integer ra_cnt = 0;
    always #4 clock_i = ~clock_i;
    // Access grants last one cycle, so they are counted as they pass.
    always @(posedge clock_i)
    begin
        fr_cnt <= fr_cnt + fr;
        ra_cnt <= ra_cnt + ra;
    end
    fpep_cpu_model u_fpep_cpu_model (.clock_i(clock_i), .op_i(op), .ev_o(ev));
    fpep_top u_fpep_top (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .hw_standby_i(stby), .ctl_a_we_i(we[0]), .ctl_a_wdata_i(wd),
        .ctl_b_we_i(we[1]), .ctl_b_wdata_i(wd), .blk_a_we_i(we[2]),
        .blk_a_wdata_i(wd), .blk_b_we_i(we[3]), .blk_b_wdata_i(wd),
        .flash_write_enable_input_i(1'b1), .bus_read_i(ev[0] | ev[1]),
        .bus_write_i(1'b0), .bus_addr_i(24'h000000), .ram_overlap_i(ev[0]),
        .exception_i(ev[2]), .sleep_i(ev[3]), .other_master_i(ev[4]),
        .ctl_a_o(ca), .ctl_b_o(cb), .block_select_reg_a_o(ba),
        .block_select_reg_b_o(bb), .program_active_o(pa),
        .erase_active_o(ea), .verify_active_o(va), .flash_read_en_o(fr),
        .ram_access_en_o(ra), .flash_error_flag_o(fl));
    task print_verdict;
    begin
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task cmp(input [47:0] nm, input [7:0] e, input [7:0] s);
    begin
        #1;
        checked = checked + 1;
        if (s !== e)
        begin
            fails = fails + 1;
            $display("wrong value %0s exp %h got %h", nm, e, s);
        end
    end
    endtask
    // Strobes and events last one cycle; the pause lets outputs settle.
    task drive(input [3:0] w, input [7:0] d, input [2:0] p, input s);
    begin
        @(posedge clock_i);
        we <= w;
        wd <= d;
        op <= p;
        stby <= s;
        @(posedge clock_i);
        we <= 4'h0;
        op <= 3'h0;
        stby <= 1'b0;
        repeat (4) @(posedge clock_i);
    end
    endtask
    initial
    begin
        #20000;
        fails = fails + 1;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        cmp("rst", 8'h00, {fl, ra, fr});
        drive(4'hC, 8'h5A, 3'h0, 1'b0);
        drive(4'h0, 8'h00, 3'h2, 1'b0);
        drive(4'h0, 8'h00, 3'h1, 1'b0);
        cmp("open", 8'h11, {fr_cnt[3:0], ra_cnt[3:0]});
        drive(4'h1, 8'h40, 3'h0, 1'b0);
        drive(4'h0, 8'h00, 3'h2, 1'b0);
        drive(4'h0, 8'h00, 3'h1, 1'b0);
        cmp("lock", 8'h12, {fr_cnt[3:0], ra_cnt[3:0]});
        cmp("noerr", 8'h00, {fl});
        drive(4'h1, 8'h41, 3'h0, 1'b0);
        cmp("prog", 8'h01, {pa});
        drive(4'h0, 8'h00, 3'h1, 1'b0);
        cmp("ramok", 8'h00, {fl});
        drive(4'h0, 8'h00, 3'h2, 1'b0);
        cmp("abort", 8'h05, {fl, pa, cb[7]});
        cmp("keepa", 8'h41, ca);
        cmp("blk", 8'h5A, ba & bb);
        drive(4'h3, 8'h03, 3'h0, 1'b0);
        cmp("retry", 8'h00, {ea, pa});
        drive(4'h1, 8'h44, 3'h0, 1'b0);
        cmp("verify", 8'h01, {va});
        drive(4'h2, 8'h00, 3'h0, 1'b0);
        cmp("sticky", 8'h01, {fl});
        for (o = 3; o < 6; o = o + 1)
        begin
            drive(4'h0, 8'h00, 3'h0, 1'b1);
            cmp("stby", 8'h00, {fl});
            drive(4'h1, 8'h40, 3'h0, 1'b0);
            drive(4'h1, 8'h42, 3'h0, 1'b0);
            drive(4'h0, 8'h00, o[2:0], 1'b0);
            cmp("event", 8'h02, {fl, ea});
        end
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        cmp("reset", 8'h00, {fl});
        print_verdict;
    end
endmodule

/* verilog/fpep_err_detect.v */
// Error condition detector for the flash program/erase protect block.
`timescale 1ns/1ns
module fpep_err_detect
(
    input wire busy_i,
    input wire flash_read_i,
    input wire exception_i,
    input wire sleep_i,
    input wire other_master_i,
    output wire error_o
);
    // Every cause only counts while a program or erase pulse is active.
    assign error_o = busy_i & (flash_read_i
                               | exception_i
                               | sleep_i
                               | other_master_i);
endmodule

/* verilog/fpep_top.v */
// Flash program/erase access control with error protection latch.
`timescale 1ns/1ns
`include "fpep_defs.vh"
module fpep_top
#(
    parameter ADDR_W = 24
)
(
    input wire clock_i,
    input wire arst_n_i,
    input wire hw_standby_i,
    input wire ctl_a_we_i,
    input wire [7:0] ctl_a_wdata_i,
    input wire ctl_b_we_i,
    input wire [7:0] ctl_b_wdata_i,
    input wire blk_a_we_i,
    input wire [7:0] blk_a_wdata_i,
    input wire blk_b_we_i,
    input wire [7:0] blk_b_wdata_i,
    input wire flash_write_enable_input_i,
    input wire bus_read_i,
    input wire bus_write_i,
    input wire [ADDR_W-1:0] bus_addr_i,
    input wire ram_overlap_i,
    input wire exception_i,
    input wire sleep_i,
    input wire other_master_i,
    output reg [7:0] ctl_a_o,
    output reg [7:0] ctl_b_o,
    output reg [7:0] block_select_reg_a_o,
    output reg [7:0] block_select_reg_b_o,
    output reg program_active_o,
    output reg erase_active_o,
    output reg verify_active_o,
    output reg flash_read_en_o,
    output reg ram_access_en_o,
    output reg flash_error_flag_o
);
    reg [7:0] flash_control_reg_a_r;
    reg [7:0] flash_control_reg_b_r;
    reg [7:0] blk_a_r;
    reg [7:0] blk_b_r;
    reg flash_error_flag_r;
    reg wen_meta_r;
    reg wen_sync_r;
    wire software_write_enable;
    wire busy;
    wire err_now;
    wire [7:0] ctl_a_nxt;
    wire [7:0] ctl_b_nxt;

    assign software_write_enable =
        flash_control_reg_a_r[`FPEP_CTLA_WREN_BIT];
    assign busy = flash_control_reg_a_r[`FPEP_CTLA_PROG_BIT]
                | flash_control_reg_a_r[`FPEP_CTLA_ERASE_BIT]
                | flash_control_reg_b_r[`FPEP_CTLB_PROG_BIT]
                | flash_control_reg_b_r[`FPEP_CTLB_ERASE_BIT];

    // A flash read only counts when it does not hit the overlapping RAM.
    fpep_err_detect u_det
    (
        .busy_i(busy),
        .flash_read_i(bus_read_i & ~ram_overlap_i),
        .exception_i(exception_i),
        .sleep_i(sleep_i),
        .other_master_i(other_master_i),
        .error_o(err_now)
    );

    // Program and erase bits stay set when protection is active; they are
    // kept in the register image but masked, so the settings are retained.
    assign ctl_a_nxt = ctl_a_we_i ? ctl_a_wdata_i : flash_control_reg_a_r;
    assign ctl_b_nxt = ctl_b_we_i ?
        {flash_control_reg_b_r[`FPEP_CTLB_ERR_BIT], ctl_b_wdata_i[6:0]} :
        flash_control_reg_b_r;

    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wen_meta_r <= 1'b0;
            wen_sync_r <= 1'b0;
        end
        else
        begin
            wen_meta_r <= flash_write_enable_input_i;
            wen_sync_r <= wen_meta_r;
        end
    end

    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flash_control_reg_a_r <= `FPEP_CTL_RESET;
            flash_control_reg_b_r <= `FPEP_CTL_RESET;
            blk_a_r <= `FPEP_BLK_RESET;
            blk_b_r <= `FPEP_BLK_RESET;
            flash_error_flag_r <= 1'b0;
        end
        else if (hw_standby_i)
        begin
            flash_control_reg_a_r <= `FPEP_CTL_RESET;
            flash_control_reg_b_r <= `FPEP_CTL_RESET;
            blk_a_r <= `FPEP_BLK_RESET;
            blk_b_r <= `FPEP_BLK_RESET;
            flash_error_flag_r <= 1'b0;
        end
        else
        begin
            // Without the write enable pin the control bits cannot take hold.
            if (wen_sync_r)
            begin
                flash_control_reg_a_r <= ctl_a_nxt;
                flash_control_reg_b_r <= ctl_b_nxt;
            end
            else
            begin
                flash_control_reg_a_r <= 8'h00;
                flash_control_reg_b_r <=
                    {flash_control_reg_b_r[`FPEP_CTLB_ERR_BIT], 7'h00};
            end
            if (blk_a_we_i)
                blk_a_r <= blk_a_wdata_i;
            if (blk_b_we_i)
                blk_b_r <= blk_b_wdata_i;
            if (err_now)
                flash_error_flag_r <= 1'b1;
        end
    end

    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctl_a_o <= 8'h00;
            ctl_b_o <= 8'h00;
            block_select_reg_a_o <= 8'h00;
            block_select_reg_b_o <= 8'h00;
            program_active_o <= 1'b0;
            erase_active_o <= 1'b0;
            verify_active_o <= 1'b0;
            flash_read_en_o <= 1'b0;
            ram_access_en_o <= 1'b0;
            flash_error_flag_o <= 1'b0;
        end
        else
        begin
            ctl_a_o <= flash_control_reg_a_r;
            ctl_b_o <= {flash_error_flag_r,
                        flash_control_reg_b_r[6:0]};
            block_select_reg_a_o <= blk_a_r;
            block_select_reg_b_o <= blk_b_r;
            // Protection masks the operation at once, even mid pulse.
            program_active_o <= ~flash_error_flag_r & ~err_now
                & (flash_control_reg_a_r[`FPEP_CTLA_PROG_BIT]
                 | flash_control_reg_b_r[`FPEP_CTLB_PROG_BIT]);
            erase_active_o <= ~flash_error_flag_r & ~err_now
                & (flash_control_reg_a_r[`FPEP_CTLA_ERASE_BIT]
                 | flash_control_reg_b_r[`FPEP_CTLB_ERASE_BIT]);
            verify_active_o <= flash_control_reg_a_r[`FPEP_CTLA_PVER_BIT]
                | flash_control_reg_a_r[`FPEP_CTLA_EVER_BIT]
                | flash_control_reg_b_r[`FPEP_CTLB_PVER_BIT]
                | flash_control_reg_b_r[`FPEP_CTLB_EVER_BIT];
            flash_read_en_o <= bus_read_i & ~ram_overlap_i
                & ~software_write_enable;
            ram_access_en_o <= (bus_read_i | bus_write_i)
                & ram_overlap_i;
            flash_error_flag_o <= flash_error_flag_r;
        end
    end
endmodule
